// ---- src/exec_pkg.sv ----
package exec_pkg;

  // ==========================================================
  // Prefixes and opcodes
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_EXT = 8'hed;
  localparam logic [7:0] PFX_IDX1 = 8'hdd;
  localparam logic [7:0] PFX_IDX2 = 8'hfd;
  localparam logic [7:0] OP_SWAP_DEST_SRC = 8'heb;
  localparam logic [7:0] OP_SWAP_ACC_SHADOW = 8'h08;
  localparam logic [7:0] OP_SWAP_ALL_SHADOW = 8'hd9;
  localparam logic [7:0] OP_SWAP_STACK = 8'he3;
  localparam logic [7:0] OP_COPY_STEP_UP = 8'ha0;
  localparam logic [7:0] OP_COPY_REPEAT_UP = 8'hb0;
  localparam logic [7:0] OP_COPY_STEP_DOWN = 8'ha8;
  localparam logic [7:0] OP_COPY_REPEAT_DOWN = 8'hb8;
  localparam logic [7:0] OP_COMPARE_STEP_UP = 8'ha1;
  localparam logic [7:0] OP_COMPARE_REPEAT_UP = 8'hb1;
  localparam logic [7:0] OP_COMPARE_STEP_DOWN = 8'ha9;
  localparam logic [7:0] OP_COMPARE_REPEAT_DOWN = 8'hb9;

  // ==========================================================
  // Timing in clock states, one clock per state
  localparam int T_SWAP = 4;
  localparam int T_SWAP_STACK = 19;
  localparam int T_SWAP_STACK_IDX = 23;
  localparam int T_BLOCK_STEP = 16;
  localparam int T_BLOCK_LOOP = 21;
  localparam int T_IGNORED = 1;
  localparam logic [4:0] TL_SWAP = 5'(T_SWAP - 1);
  localparam logic [4:0] TL_SWAP_STACK = 5'(T_SWAP_STACK - 1);
  localparam logic [4:0] TL_SWAP_STACK_IDX = 5'(T_SWAP_STACK_IDX - 1);
  localparam logic [4:0] TL_BLOCK_STEP = 5'(T_BLOCK_STEP - 1);
  localparam logic [4:0] TL_BLOCK_LOOP = 5'(T_BLOCK_LOOP - 1);
  localparam logic [4:0] TL_IGNORED = 5'(T_IGNORED - 1);

  // Memory access slots within an instruction
  localparam logic [4:0] STK_RD_LO = 5'h03;
  localparam logic [4:0] STK_RD_HI = 5'h06;
  localparam logic [4:0] STK_WR_HI_BACK = 5'h07;
  localparam logic [4:0] STK_WR_LO_BACK = 5'h03;
  localparam logic [4:0] BLK_RD = 5'h03;
  localparam logic [4:0] BLK_WR = 5'h07;

  // ==========================================================
  // Flag bit positions and reset values
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam logic [15:0] PAIR_RESET = 16'h0000;
  localparam logic [4:0] TCNT_RESET = 5'h00;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_LOOP = 2'b11
  } state_t;

  typedef enum logic [2:0] {
    K_NONE,
    K_SWAP_DEST_SRC,
    K_SWAP_ACC,
    K_SWAP_ALL,
    K_SWAP_STACK,
    K_COPY,
    K_COMPARE
  } kind_t;

  typedef enum logic [1:0] {
    SEL_SOURCE,
    SEL_FIRST_INDEX,
    SEL_SECOND_INDEX
  } sel_t;

  typedef struct packed {
    logic [7:0] prefix;
    logic [7:0] opcode;
  } insn_t;

  typedef struct packed {
    kind_t kind;
    logic down;
    logic repeat_op;
    sel_t sel;
    logic [4:0] tlast;
  } dec_t;

  typedef struct packed {
    logic [15:0] accumulator_flag_pair;
    logic [15:0] count_pair;
    logic [15:0] destination_pair;
    logic [15:0] source_pair;
    logic [15:0] shadow_accumulator_flag_pair;
    logic [15:0] shadow_count_pair;
    logic [15:0] shadow_destination_pair;
    logic [15:0] shadow_source_pair;
    logic [15:0] first_index_register;
    logic [15:0] second_index_register;
    logic [15:0] stack_pointer;
  } regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mem_req_t;

endpackage : exec_pkg

// ---- src/insn_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module insn_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers, one extra bit tells full from empty
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_q;
  logic [AW:0] rd_d;
  logic full;
  logic empty;
  logic push;
  logic pop;

  always_comb begin
    empty = (wr_q == rd_q);
    full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    in_ready = !full;
    out_valid = !empty;
    out_data = mem_q[rd_q[AW-1:0]];
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Data array needs no reset; only pointers decide validity
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule : insn_fifo

`default_nettype wire

// ---- src/exchange_block_move_search_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Opcode eb swaps destination and source pairs and 08 swaps the accumulator-flag pair with its shadow, 4 states.
// - Opcode d9 swaps count, destination and source pairs with their shadows in one 4-state instruction.
// - Opcode e3 swaps the source pair low byte with memory at the stack pointer and high byte at the next, 19 states.
// - Prefixes dd and fd apply that stack swap to the first or second index register in 23 states.
// - Extended a0 copies source byte to destination, bumps both pointers up and counts down once in 16 states.
// - Extended b0 repeats that copy until the count is zero, 21 states per continuing pass and 16 on the last.
// - Extended b8 repeats a copy stepping both pointers and the count down until the count is zero.
// - Extended b1 repeats the upward compare until a match or zero count, 21 states per pass and 16 on the last.
// - Repeating searches update the zero flag only when the whole instruction ends.
module exchange_block_move_search_exec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire exec_pkg::insn_t in_insn,
  input wire logic load_valid,
  input wire exec_pkg::regs_t load_regs,
  output exec_pkg::regs_t regs,
  output exec_pkg::mem_req_t mem,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done
);

  import exec_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] step16(input logic [15:0] v, input logic down);
    step16 = down ? v - 16'h0001 : v + 16'h0001;
  endfunction : step16

  function automatic dec_t decode(input insn_t i);
    decode.kind = K_NONE;
    decode.down = 1'b0;
    decode.repeat_op = 1'b0;
    decode.sel = SEL_SOURCE;
    decode.tlast = TL_IGNORED;
    if (i.prefix == PFX_NONE) begin
      case (i.opcode)
        OP_SWAP_DEST_SRC: begin
          decode.kind = K_SWAP_DEST_SRC;
          decode.tlast = TL_SWAP;
        end
        OP_SWAP_ACC_SHADOW: begin
          decode.kind = K_SWAP_ACC;
          decode.tlast = TL_SWAP;
        end
        OP_SWAP_ALL_SHADOW: begin
          decode.kind = K_SWAP_ALL;
          decode.tlast = TL_SWAP;
        end
        OP_SWAP_STACK: begin
          decode.kind = K_SWAP_STACK;
          decode.tlast = TL_SWAP_STACK;
        end
        default: begin
          decode.kind = K_NONE;
        end
      endcase
    end else if ((i.prefix == PFX_IDX1 || i.prefix == PFX_IDX2) && i.opcode == OP_SWAP_STACK) begin
      decode.kind = K_SWAP_STACK;
      decode.sel = (i.prefix == PFX_IDX1) ? SEL_FIRST_INDEX : SEL_SECOND_INDEX;
      decode.tlast = TL_SWAP_STACK_IDX;
    end else if (i.prefix == PFX_EXT) begin
      decode.tlast = TL_BLOCK_STEP;
      decode.repeat_op = i.opcode[4];
      decode.down = i.opcode[3];
      case (i.opcode)
        OP_COPY_STEP_UP, OP_COPY_REPEAT_UP, OP_COPY_STEP_DOWN, OP_COPY_REPEAT_DOWN: begin
          decode.kind = K_COPY;
        end
        OP_COMPARE_STEP_UP, OP_COMPARE_REPEAT_UP, OP_COMPARE_STEP_DOWN, OP_COMPARE_REPEAT_DOWN: begin
          decode.kind = K_COMPARE;
        end
        default: begin
          decode.kind = K_NONE;
          decode.repeat_op = 1'b0;
          decode.tlast = TL_IGNORED;
        end
      endcase
    end
  endfunction : decode

  function automatic logic [15:0] get_pair(input regs_t r, input sel_t s);
    case (s)
      SEL_FIRST_INDEX: get_pair = r.first_index_register;
      SEL_SECOND_INDEX: get_pair = r.second_index_register;
      default: get_pair = r.source_pair;
    endcase
  endfunction : get_pair

  // ==========================================================
  // Instruction queue; stalls the source only when all 16 entries are full
  logic fifo_valid;
  logic fifo_ready;
  logic [15:0] fifo_data;
  insn_t fifo_insn;

  insn_fifo #(
    .WIDTH($bits(insn_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_insn),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // ==========================================================
  // Execution state
  state_t st_q;
  state_t st_d;
  logic [4:0] tcnt_q;
  logic [4:0] tcnt_d;
  dec_t cur_q;
  dec_t cur_d;
  regs_t regs_q;
  regs_t regs_d;
  mem_req_t mem_q;
  mem_req_t mem_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic done_q;
  logic done_d;

  logic [15:0] pair;
  logic [15:0] count_next;
  logic [7:0] acc;
  logic [7:0] diff;
  logic match;
  logic finish;

  always_comb begin
    fifo_insn = insn_t'(fifo_data);
    // Loading has priority so a test can seed registers between instructions
    fifo_ready = (st_q == ST_IDLE) && !load_valid;
    st_d = st_q;
    tcnt_d = tcnt_q;
    cur_d = cur_q;
    regs_d = regs_q;
    lo_d = lo_q;
    hi_d = hi_q;
    done_d = 1'b0;
    mem_d = '0;
    mem_d.addr = mem_q.addr;
    pair = get_pair(regs_q, cur_q.sel);
    count_next = regs_q.count_pair - 16'h0001;
    acc = regs_q.accumulator_flag_pair[15:8];
    diff = acc - lo_q;
    match = (diff == 8'h00);
    finish = !cur_q.repeat_op || (count_next == 16'h0000) || (cur_q.kind == K_COMPARE && match);
    case (st_q)
      ST_IDLE: begin
        tcnt_d = TCNT_RESET;
        if (load_valid) begin
          regs_d = load_regs;
        end else if (fifo_valid) begin
          cur_d = decode(fifo_insn);
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        tcnt_d = tcnt_q + 5'h01;
        case (cur_q.kind)
          K_SWAP_STACK: begin
            if (tcnt_q == STK_RD_LO) begin
              mem_d.rd = 1'b1;
              mem_d.addr = regs_q.stack_pointer;
            end
            if (tcnt_q == STK_RD_LO + 5'h01) begin
              lo_d = mem_rdata;
            end
            if (tcnt_q == STK_RD_HI) begin
              mem_d.rd = 1'b1;
              mem_d.addr = step16(regs_q.stack_pointer, 1'b0);
            end
            if (tcnt_q == STK_RD_HI + 5'h01) begin
              hi_d = mem_rdata;
            end
            if (tcnt_q == cur_q.tlast - STK_WR_HI_BACK) begin
              mem_d.wr = 1'b1;
              mem_d.addr = step16(regs_q.stack_pointer, 1'b0);
              mem_d.wdata = pair[15:8];
            end
            if (tcnt_q == cur_q.tlast - STK_WR_LO_BACK) begin
              mem_d.wr = 1'b1;
              mem_d.addr = regs_q.stack_pointer;
              mem_d.wdata = pair[7:0];
            end
          end
          K_COPY, K_COMPARE: begin
            if (tcnt_q == BLK_RD) begin
              mem_d.rd = 1'b1;
              mem_d.addr = regs_q.source_pair;
            end
            if (tcnt_q == BLK_RD + 5'h01) begin
              lo_d = mem_rdata;
            end
            if (cur_q.kind == K_COPY && tcnt_q == BLK_WR) begin
              mem_d.wr = 1'b1;
              mem_d.addr = regs_q.destination_pair;
              mem_d.wdata = lo_q;
            end
          end
          default: begin
            mem_d.rd = 1'b0;
          end
        endcase
        if (tcnt_q == cur_q.tlast) begin
          case (cur_q.kind)
            K_SWAP_DEST_SRC: begin
              regs_d.destination_pair = regs_q.source_pair;
              regs_d.source_pair = regs_q.destination_pair;
            end
            K_SWAP_ACC: begin
              regs_d.accumulator_flag_pair = regs_q.shadow_accumulator_flag_pair;
              regs_d.shadow_accumulator_flag_pair = regs_q.accumulator_flag_pair;
            end
            K_SWAP_ALL: begin
              regs_d.count_pair = regs_q.shadow_count_pair;
              regs_d.shadow_count_pair = regs_q.count_pair;
              regs_d.destination_pair = regs_q.shadow_destination_pair;
              regs_d.shadow_destination_pair = regs_q.destination_pair;
              regs_d.source_pair = regs_q.shadow_source_pair;
              regs_d.shadow_source_pair = regs_q.source_pair;
            end
            K_SWAP_STACK: begin
              case (cur_q.sel)
                SEL_FIRST_INDEX: regs_d.first_index_register = {hi_q, lo_q};
                SEL_SECOND_INDEX: regs_d.second_index_register = {hi_q, lo_q};
                default: regs_d.source_pair = {hi_q, lo_q};
              endcase
            end
            K_COPY: begin
              regs_d.destination_pair = step16(regs_q.destination_pair, cur_q.down);
              regs_d.source_pair = step16(regs_q.source_pair, cur_q.down);
              regs_d.count_pair = count_next;
              regs_d.accumulator_flag_pair[FLAG_H] = 1'b0;
              regs_d.accumulator_flag_pair[FLAG_N] = 1'b0;
              regs_d.accumulator_flag_pair[FLAG_PV] = (count_next != 16'h0000);
            end
            K_COMPARE: begin
              // Accumulator itself is never written, only flags
              regs_d.source_pair = step16(regs_q.source_pair, cur_q.down);
              regs_d.count_pair = count_next;
              regs_d.accumulator_flag_pair[FLAG_S] = diff[7];
              regs_d.accumulator_flag_pair[FLAG_H] = (acc[3:0] < lo_q[3:0]);
              regs_d.accumulator_flag_pair[FLAG_PV] = (count_next != 16'h0000);
              regs_d.accumulator_flag_pair[FLAG_N] = 1'b1;
              if (finish) begin
                regs_d.accumulator_flag_pair[FLAG_Z] = match;
              end
            end
            default: begin
              regs_d.stack_pointer = regs_q.stack_pointer;
            end
          endcase
          if ((cur_q.kind == K_COPY || cur_q.kind == K_COMPARE) && !finish) begin
            st_d = ST_LOOP;
          end else begin
            st_d = ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
      ST_LOOP: begin
        // Extra states of a continuing pass, then the next pass starts over
        if (tcnt_q == TL_BLOCK_LOOP) begin
          tcnt_d = TCNT_RESET;
          st_d = ST_RUN;
        end else begin
          tcnt_d = tcnt_q + 5'h01;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      tcnt_q <= TCNT_RESET;
      cur_q <= '0;
      regs_q <= {11{PAIR_RESET}};
      mem_q <= '0;
      lo_q <= '0;
      hi_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tcnt_q <= tcnt_d;
      cur_q <= cur_d;
      regs_q <= regs_d;
      mem_q <= mem_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    regs = regs_q;
    mem = mem_q;
    done = done_q;
    busy = (st_q != ST_IDLE);
  end

endmodule : exchange_block_move_search_exec

`default_nettype wire

// ---- verification/exec_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire exec_pkg::insn_t in_insn,
  input wire logic load_valid,
  input wire exec_pkg::regs_t load_regs,
  input wire exec_pkg::regs_t regs,
  input wire exec_pkg::mem_req_t mem,
  input wire logic [7:0] mem_rdata,
  input wire logic busy,
  input wire logic done
);
  import exec_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ======
  // Busy run length, so one rule covers every instruction kind
  logic [31:0] len_q;
  logic [31:0] len_d;
  always_comb len_d = busy ? len_q + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) len_q <= 32'h0;
    else len_q <= len_d;
  end
  // ======
  // Memory step patterns
  sequence s_stack_rd; mem.rd ##3 mem.rd; endsequence
  sequence s_stack_wr; mem.wr ##4 mem.wr; endsequence
  sequence s_copy; mem.rd ##4 mem.wr; endsequence
  chk_done_pulse: assert property (done |-> !busy ##1 !done)
    else $error("done is not a lone idle pulse");
  chk_busy_length: assert property (done |-> len_q == T_IGNORED || len_q == T_SWAP || len_q == T_SWAP_STACK ||
    len_q == T_SWAP_STACK_IDX || (len_q >= T_BLOCK_STEP && (len_q - T_BLOCK_STEP) % T_BLOCK_LOOP == 0))
    else $error("instruction length not a legal state count");
  chk_mem_busy: assert property ((mem.rd || mem.wr) |-> busy && !(mem.rd && mem.wr))
    else $error("memory strobe outside an instruction");
  chk_rd_pulse: assert property (mem.rd |=> !mem.rd)
    else $error("read strobe longer than one cycle");
  chk_stack_reads: assert property (s_stack_rd |-> mem.addr == $past(mem.addr, 3) + 16'h1 &&
    $past(mem.addr, 3) == regs.stack_pointer)
    else $error("stack reads not at top and top plus one");
  chk_stack_writes: assert property (s_stack_wr |-> mem.addr == $past(mem.addr, 4) - 16'h1 &&
    mem.addr == regs.stack_pointer)
    else $error("stack writes not high then low");
  chk_stack_done: assert property (s_stack_rd |-> (##12 done) or (##16 done))
    else $error("stack swap end at wrong time");
  chk_copy_write: assert property (s_copy |-> mem.wdata == $past(mem_rdata, 4) &&
    mem.addr == regs.destination_pair)
    else $error("copied byte or target wrong");
  chk_zero_hold: assert property ($changed(regs.accumulator_flag_pair[FLAG_Z]) |-> done || $past(load_valid))
    else $error("zero flag changed before completion");
endmodule : exec_checker
bind exchange_block_move_search_exec exec_checker u_chk (.clk(clk), .rst_b(rst_b), .in_valid(in_valid),
  .in_ready(in_ready), .in_insn(in_insn), .load_valid(load_valid), .load_regs(load_regs), .regs(regs),
  .mem(mem), .mem_rdata(mem_rdata), .busy(busy), .done(done));
`default_nettype wire

// ---- verification/mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire exec_pkg::mem_req_t mem,
  output logic [7:0] rdata
);
  import exec_pkg::*;
  // ======
  // Byte store, low address byte only
  logic [7:0] cells [256];
  logic [7:0] churn_q;
  // Read data stands only in the strobe cycle, which is when the core takes it
  // Data churns outside a read, so a late sample never looks valid
  always_comb rdata = mem.rd ? cells[mem.addr[7:0]] : churn_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      churn_q <= 8'h00;
    end else begin
      churn_q <= ~churn_q;
      if (mem.wr) begin
        cells[mem.addr[7:0]] <= mem.wdata;
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// ---- verification/exchange_block_move_search_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module exchange_block_move_search_exec_bench;
  import exec_pkg::*;
  // ======
  // Ports and bookkeeping
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic in_valid = 1'b0;
  insn_t in_insn = '0;
  logic load_valid = 1'b0;
  regs_t load_regs = '0;
  regs_t regs;
  mem_req_t mem;
  logic [7:0] mem_rdata;
  logic in_ready;
  logic busy;
  logic done;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  regs_t base;
  regs_t r;
  wire [15:0] acc_flags = regs.accumulator_flag_pair;
  wire [15:0] cnt = regs.count_pair;
  wire [15:0] dst = regs.destination_pair;
  wire [15:0] src = regs.source_pair;
  exchange_block_move_search_exec dut (.clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
    .in_insn(in_insn), .load_valid(load_valid), .load_regs(load_regs), .regs(regs), .mem(mem),
    .mem_rdata(mem_rdata), .busy(busy), .done(done));
  mem_model ram (.clk(clk), .rst_b(rst_b), .mem(mem), .rdata(mem_rdata));
  initial begin
    forever #20 clk = ~clk;
  end
  // Tests need under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic ptrs(input logic [15:0] c, input logic [15:0] d, input logic [15:0] s);
    check("count", 32'(c), 32'(cnt));
    check("dest", 32'(d), 32'(dst));
    check("source", 32'(s), 32'(src));
  endtask : ptrs
  task automatic mchk(input logic [7:0] a, input logic [7:0] v);
    check("memory", 32'(v), 32'(ram.cells[a]));
  endtask : mchk
  task automatic load(input regs_t x);
    @(posedge clk);
    load_valid <= 1'b1;
    load_regs <= x;
    @(posedge clk);
    load_valid <= 1'b0;
  endtask : load
  // Latency counted from the edge that takes the word
  task automatic run(input logic [7:0] pfx, input logic [7:0] op, input int n);
    int c;
    c = 0;
    @(posedge clk);
    in_insn <= {pfx, op};
    in_valid <= 1'b1;
    @(posedge clk);
    in_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (done !== 1'b1 && c < 2000);
    check("latency", 32'(n + 1), 32'(c));
  endtask : run
  // ======
  // Scenarios
  task automatic t_reset;
    #1;
    check("ready", 32'h1, 32'(in_ready));
    check("busy", 32'h0, 32'(busy));
    check("done", 32'h0, 32'(done));
    check("mem", 32'h0, 32'(mem));
    check("sp", 32'h0, 32'(regs.stack_pointer));
    ptrs(16'h0, 16'h0, 16'h0);
  endtask : t_reset
  task automatic t_swap;
    load(base);
    run(PFX_NONE, OP_SWAP_DEST_SRC, T_SWAP);
    ptrs(16'h0003, 16'h0080, 16'h00c0);
    run(PFX_NONE, OP_SWAP_ACC_SHADOW, T_SWAP);
    check("flags", 32'h3401, 32'(acc_flags));
    check("shadow flags", 32'h1212, 32'(regs.shadow_accumulator_flag_pair));
    run(PFX_NONE, OP_SWAP_ALL_SHADOW, T_SWAP);
    ptrs(16'h5601, 16'h7802, 16'h9a03);
    check("shadow src", 32'h00c0, 32'(regs.shadow_source_pair));
    run(PFX_EXT, 8'h00, T_IGNORED);
    ptrs(16'h5601, 16'h7802, 16'h9a03);
  endtask : t_swap
  task automatic t_stack;
    load(base);
    ram.cells[8'h40] = 8'h11;
    ram.cells[8'h41] = 8'h22;
    run(PFX_NONE, OP_SWAP_STACK, T_SWAP_STACK);
    check("source", 32'h2211, 32'(src));
    mchk(8'h40, 8'h80);
    mchk(8'h41, 8'h00);
    run(PFX_IDX1, OP_SWAP_STACK, T_SWAP_STACK_IDX);
    check("idx1", 32'h0080, 32'(regs.first_index_register));
    run(PFX_IDX2, OP_SWAP_STACK, T_SWAP_STACK_IDX);
    check("idx2", 32'hbc04, 32'(regs.second_index_register));
    mchk(8'h40, 8'h05);
    mchk(8'h41, 8'hde);
  endtask : t_stack
  task automatic t_copy;
    load(base);
    ram.cells[8'h80] = 8'ha5;
    ram.cells[8'h81] = 8'h5a;
    run(PFX_EXT, OP_COPY_STEP_UP, T_BLOCK_STEP);
    mchk(8'hc0, 8'ha5);
    ptrs(16'h0002, 16'h00c1, 16'h0081);
    check("flags", 32'h1204, 32'(acc_flags & 16'hffd7));
    run(PFX_EXT, OP_COPY_STEP_DOWN, T_BLOCK_STEP);
    mchk(8'hc1, 8'h5a);
    ptrs(16'h0001, 16'h00c0, 16'h0080);
  endtask : t_copy
  task automatic t_copy_repeat;
    load(base);
    for (int i = 0; i < 3; i++) ram.cells[8'h80 + i] = 8'(i + 1);
    run(PFX_EXT, OP_COPY_REPEAT_UP, 2 * T_BLOCK_LOOP + T_BLOCK_STEP);
    for (int i = 0; i < 3; i++) mchk(8'hc0 + 8'(i), 8'(i + 1));
    ptrs(16'h0000, 16'h00c3, 16'h0083);
    check("flags", 32'h1200, 32'(acc_flags & 16'hffd7));
    r = base;
    r.count_pair = 16'h0002;
    r.source_pair = 16'h0082;
    r.destination_pair = 16'h00d2;
    load(r);
    run(PFX_EXT, OP_COPY_REPEAT_DOWN, T_BLOCK_LOOP + T_BLOCK_STEP);
    mchk(8'hd2, 8'h03);
    mchk(8'hd1, 8'h02);
    ptrs(16'h0000, 16'h00d0, 16'h0080);
  endtask : t_copy_repeat
  task automatic t_compare;
    load(base);
    ram.cells[8'h80] = 8'h12;
    ram.cells[8'h81] = 8'h13;
    run(PFX_EXT, OP_COMPARE_STEP_UP, T_BLOCK_STEP);
    check("flags", 32'h1246, 32'(acc_flags & 16'hffd7));
    ptrs(16'h0002, 16'h00c0, 16'h0081);
    run(PFX_EXT, OP_COMPARE_STEP_DOWN, T_BLOCK_STEP);
    check("flags", 32'h1296, 32'(acc_flags & 16'hffd7));
    ptrs(16'h0001, 16'h00c0, 16'h0080);
  endtask : t_compare
  task automatic t_search;
    r = base;
    r.count_pair = 16'h0005;
    load(r);
    ram.cells[8'h80] = 8'h00;
    ram.cells[8'h81] = 8'h00;
    ram.cells[8'h82] = 8'h12;
    ram.cells[8'h83] = 8'h00;
    ram.cells[8'h84] = 8'h00;
    run(PFX_EXT, OP_COMPARE_REPEAT_UP, 2 * T_BLOCK_LOOP + T_BLOCK_STEP);
    ptrs(16'h0002, 16'h00c0, 16'h0083);
    check("flags", 32'h1246, 32'(acc_flags & 16'hffd7));
    r.accumulator_flag_pair = 16'h1240;
    r.count_pair = 16'h0002;
    r.source_pair = 16'h0084;
    load(r);
    run(PFX_EXT, OP_COMPARE_REPEAT_DOWN, T_BLOCK_LOOP + T_BLOCK_STEP);
    ptrs(16'h0000, 16'h00c0, 16'h0082);
    check("flags", 32'h1202, 32'(acc_flags & 16'hffd7));
  endtask : t_search
  // Loading holds the core idle, which lets the queue fill
  task automatic t_fifo;
    int c;
    int k;
    c = 0;
    k = 0;
    @(posedge clk);
    load_valid <= 1'b1;
    load_regs <= base;
    in_insn <= {PFX_NONE, OP_SWAP_DEST_SRC};
    in_valid <= 1'b1;
    repeat (FIFO_DEPTH + 1) @(posedge clk);
    in_valid <= 1'b0;
    #1;
    check("ready", 32'h0, 32'(in_ready));
    @(posedge clk);
    load_valid <= 1'b0;
    while (k < FIFO_DEPTH && c < 400) begin
      @(posedge clk);
      #1;
      c++;
      if (done === 1'b1) k++;
    end
    check("done count", 32'(FIFO_DEPTH), 32'(k));
    check("ready", 32'h1, 32'(in_ready));
    ptrs(16'h0003, 16'h00c0, 16'h0080);
  endtask : t_fifo
  initial begin
    base = {16'h1212, 16'h0003, 16'h00c0, 16'h0080, 16'h3401, 16'h5601, 16'h7802, 16'h9a03, 16'hbc04,
      16'hde05, 16'h0040};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_swap();
    t_stack();
    t_copy();
    t_copy_repeat();
    t_compare();
    t_search();
    t_fifo();
    results();
  end
endmodule : exchange_block_move_search_exec_bench
`default_nettype wire
